/* File: logic/eab_fifo.sv */
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module eab_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0] cnt_reg;
    logic push, pop;
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage and pointers
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : eab_fifo
`default_nettype wire

/* File: logic/eab_if.sv */
// backplane carrier joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface eab_if;
    import eab_pkg::*;
    logic link_clk;
    logic [DATA_W-1:0] m_data_o, s_data_o;
    logic m_data_oe_n, s_data_oe_n;
    logic [LANES-1:0] byte_lane_enable_n;
    logic [7:0] upper_addr_byte_n;
    logic [7:0] mid_addr_byte;
    logic [15:0] low_addr;
    logic mem_io, wr_rd, start_n, oe_n;
    logic [NUM_SLOTS:1] slot_io_addr_enable_n;
    logic master_half_word_n, master_burst_cap_n;
    logic memory_half_word_cap_n, slave_byte_xfer_n;
    logic slave_half_xfer_n, slave_word_xfer_n, slave_burst_cap_n;
    logic [DATA_W-1:0] data;
    assign data = !m_data_oe_n ? m_data_o :
                  !s_data_oe_n ? s_data_o : '1;
    modport master (
        output link_clk, m_data_o, m_data_oe_n, byte_lane_enable_n,
        output upper_addr_byte_n, mid_addr_byte, low_addr, mem_io,
        output wr_rd, start_n, oe_n, slot_io_addr_enable_n,
        output master_half_word_n, master_burst_cap_n,
        input data, memory_half_word_cap_n, slave_byte_xfer_n,
        input slave_half_xfer_n, slave_word_xfer_n, slave_burst_cap_n
    );
    modport slave (
        input link_clk, byte_lane_enable_n, upper_addr_byte_n,
        input mid_addr_byte, low_addr, mem_io, wr_rd, start_n, oe_n,
        input slot_io_addr_enable_n, master_half_word_n,
        input master_burst_cap_n, data,
        output s_data_o, s_data_oe_n, memory_half_word_cap_n,
        output slave_byte_xfer_n, slave_half_xfer_n, slave_word_xfer_n,
        output slave_burst_cap_n
    );
endinterface : eab_if
`default_nettype wire

/* File: logic/eab_master.sv */
// bus master end: link clock, qualifiers, sizing, slot enables
// Operation
// [R1] drive data only while selected
// [R2] master sets data direction each transfer
// [R3] byte enables mark valid data lanes
// [R4] byte enables clocked, handed over on master request
// [R5] upper address byte driven active low
// [R6] upper address released only on master request
// [R7] mid address on own lines, no latch strobe
// [R8] slot signals point to point, 14 slots max
// [R9] half word indication on 16-bit transfers
// [R10] shared io ranges enable all slots
// [R11] slot io ranges enable matching slot only
// [R12] peripherals decode enable, optional ignore
// [R13] memory slave decodes 16k half word regions
// [R14] cycle type high memory, low io
// [R15] direction high write, low read
// [R16] qualifiers released only on master request
// [R17] slave answers byte exchange capability
// [R18] slave answers half word exchange capability
// [R19] memory slave answers word exchange capability
// [R20] non-master board flags burst support
// [R21] master burst flag, released on master request
// [R22] arbiter grants highest priority requester
// [R23] open-collector lines wired-and, idle high
// [R24] widest permitted width, fall back to byte
`timescale 1ns/1ps
`default_nettype none
module eab_master (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // requests from slots
    input wire logic [eab_pkg::NUM_SLOTS:1] slot_master_req_n,
    input wire logic legacy_bus_req_n,
    input wire logic [eab_pkg::NUM_SLOTS:1] slot_dma_req_n,
    output logic [eab_pkg::NUM_SLOTS:1] slot_master_grant_n,
    // transfer requests
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [eab_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [eab_pkg::DATA_W-1:0] cmd_wdata,
    input wire logic [eab_pkg::LANES-1:0] cmd_lanes,
    input wire logic cmd_mem,
    input wire logic cmd_write,
    input wire logic burst_capable,
    // transfer result
    output logic rsp_valid,
    output logic [eab_pkg::DATA_W-1:0] rsp_rdata,
    output eab_pkg::eab_width_t rsp_width,
    // backplane
    eab_if.master bus
);
    import eab_pkg::*;
    typedef enum logic [1:0] {IDLE, ADDR, SIZE, DONE} eab_mst_t;
    eab_mst_t st_reg;
    logic [7:0] div_reg;
    logic lclk_reg, tick;
    logic [7:0] wait_reg;
    logic handed_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [LANES-1:0] lanes_reg;
    logic mem_reg, wr_reg, drive_reg, start_reg, half_reg;
    logic [NUM_SLOTS:1] grant_reg, req;
    eab_width_t width_reg, width_next;
    logic take;
    // start strobe and data drive share one notion of a live cycle
    function automatic logic in_cycle(input eab_mst_t s);
        in_cycle = s == ADDR || s == SIZE;
    endfunction : in_cycle
    // commands wait while a slot owns the bus
    assign cmd_ready = st_reg == IDLE && !handed_reg;
    assign take = cmd_valid && cmd_ready;
    assign req = ~slot_master_req_n;
    // legacy bus and dma requests are left unread on purpose: for them
    // this master keeps every driver, so there is nothing to hand over
    // link clock divided down from mclk, tick on each rising edge
    // it runs free between transfers; slaves qualify on start_n only
    assign tick = div_reg == 8'(LINK_DIV - 1) && !lclk_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_reg <= '0;
            lclk_reg <= 1'b0;
        end else if (div_reg == 8'(LINK_DIV - 1)) begin
            div_reg <= '0;
            lclk_reg <= !lclk_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    // fixed priority grant, lowest slot wins; held while requested
    // fixed priority can starve high slots, fine for a short list
    // no grant in the edge that takes a transfer, else that transfer
    // would run with its drivers already handed over
    always_ff @(posedge mclk) begin
        if (rst) begin
            grant_reg <= '0;
        end else if (tick && st_reg == IDLE && !take) begin
            if ((grant_reg & req) == '0) begin
                grant_reg <= req & (~req + 14'h0001); // R22 R8
            end
        end
    end
    // handover only on master request; bus/dma requests keep drivers
    // oe_n and cmd_ready share this level so they never disagree
    assign handed_reg = grant_reg != '0; // R4 R6 R16 R21
    // transfer sequencer
    // size answers get SIZE_WAIT_CYC cycles to settle; a slower slave
    // needs a longer wait constant, there is no retry
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= IDLE;
            wait_reg <= '0;
        end else begin
            unique case (st_reg)
                IDLE: if (cmd_valid && cmd_ready) st_reg <= ADDR;
                ADDR: if (tick) begin
                    st_reg <= SIZE;
                    wait_reg <= '0;
                end
                SIZE: begin
                    wait_reg <= wait_reg + 8'h01;
                    if (wait_reg == 8'(SIZE_WAIT_CYC - 1)) st_reg <= DONE;
                end
                DONE: st_reg <= IDLE;
            endcase
        end
    end
    // latch the transfer
    // qualifiers stay put afterwards so they never glitch between cycles
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_reg <= '0;
            wdata_reg <= '0;
            lanes_reg <= '0;
            mem_reg <= QUAL_MEM;
            wr_reg <= QUAL_RD;
        end else if (cmd_valid && cmd_ready) begin
            addr_reg <= cmd_addr;
            wdata_reg <= cmd_wdata;
            lanes_reg <= cmd_lanes; // R3
            mem_reg <= cmd_mem ? QUAL_MEM : QUAL_IO; // R14
            wr_reg <= cmd_write ? QUAL_WR : QUAL_RD; // R15
        end
    end
    // width from wired-and size answers, widest first
    // memory half capability counts on memory cycles only; an io slave
    // must answer with the half exchange line instead
    always_comb begin
        width_next = EAB_W8; // R24
        if (!bus.slave_word_xfer_n && mem_reg == QUAL_MEM) begin
            width_next = EAB_W32; // R19
        end else if (!bus.slave_half_xfer_n) begin
            width_next = EAB_W16; // R18
        end else if (!bus.memory_half_word_cap_n
                     && mem_reg == QUAL_MEM) begin
            width_next = EAB_W16; // R13
        end
    end
    // strobes, data drive and sampling
    // rsp pulse lasts one cycle; data holds to the next answer, width only to the next SIZE state
    always_ff @(posedge mclk) begin
        if (rst) begin
            start_reg <= 1'b0;
            drive_reg <= 1'b0;
            half_reg <= 1'b0;
            width_reg <= EAB_W8;
            rdata_reg <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            start_reg <= in_cycle(st_reg);
            drive_reg <= in_cycle(st_reg) && wr_reg == QUAL_WR; // R1 R2
            if (st_reg == SIZE) begin
                width_reg <= width_next;
                half_reg <= width_next == EAB_W16; // R9
            end
            if (st_reg == DONE) begin
                rdata_reg <= bus.data;
                rsp_valid <= 1'b1;
                half_reg <= 1'b0;
            end
        end
    end
    assign rsp_rdata = rdata_reg;
    assign rsp_width = width_reg;
    assign slot_master_grant_n = ~grant_reg;
    // backplane drive; released lines float to pull-up level
    // oe_n high tells the far side that the drivers are handed over
    assign bus.link_clk = lclk_reg;
    assign bus.oe_n = handed_reg;
    assign bus.m_data_o = wdata_reg;
    assign bus.m_data_oe_n = !(drive_reg && !handed_reg); // R1
    assign bus.byte_lane_enable_n = ~lanes_reg; // R3
    assign bus.upper_addr_byte_n = ~addr_reg[UPPER_LSB +: 8]; // R5
    assign bus.mid_addr_byte = addr_reg[MID_LSB +: 8]; // R7
    assign bus.low_addr = addr_reg[15:0];
    assign bus.mem_io = mem_reg;
    assign bus.wr_rd = wr_reg;
    assign bus.start_n = !start_reg;
    assign bus.master_half_word_n = !half_reg; // R9 R23
    assign bus.master_burst_cap_n = !burst_capable; // R21
    // slot io enables only on io cycles
    // gated by start so no io peripheral is woken between cycles
    assign bus.slot_io_addr_enable_n = (start_reg && mem_reg == QUAL_IO)
        ? ~eab_io_enable(addr_reg) : '1; // R10 R11
endmodule : eab_master
`default_nettype wire

/* File: logic/eab_pkg.sv */
// shared constants for the extended backplane master and slave ends
package eab_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int LANES = 4;
    localparam int UPPER_LSB = 24;
    localparam int MID_LSB = 16;
    localparam int NUM_SLOTS = 14;
    localparam int IO_LOW_W = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int MEM_DEC_LSB = 14;
    localparam int SLOT_NIB_LSB = 12;
    localparam int SUB_NIB_LSB = 8;
    // timing
    localparam int CLK_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_DIV = LINK_PERIOD_NS / (2 * CLK_NS);
    localparam int SIZE_WAIT_NS = 100;
    localparam int SIZE_WAIT_CYC = (SIZE_WAIT_NS + CLK_NS - 1) / CLK_NS;
    // cycle qualifiers
    localparam logic QUAL_MEM = 1'b1;
    localparam logic QUAL_IO = 1'b0;
    localparam logic QUAL_WR = 1'b1;
    localparam logic QUAL_RD = 1'b0;
    typedef enum logic [1:0] {
        EAB_W8,
        EAB_W16,
        EAB_W32
    } eab_width_t;
    // per-slot io enable decode: shared nibble ranges or slot-specific
    function automatic logic [NUM_SLOTS:1] eab_io_enable(
        input logic [ADDR_W-1:0] addr
    );
        logic [1:0] sub;
        logic [3:0] slot;
        sub = addr[SUB_NIB_LSB +: 2];
        slot = addr[SLOT_NIB_LSB +: 4];
        eab_io_enable = '0;
        if (sub != 2'h0) begin
            eab_io_enable = '1;
        end else if (slot >= 4'h1 && slot <= 4'he) begin
            eab_io_enable[slot] = 1'b1;
        end
    endfunction : eab_io_enable
endpackage : eab_pkg

/* File: logic/eab_slave.sv */
// memory/io slave end with a fifo on its write data path
`timescale 1ns/1ps
`default_nettype none
module eab_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration
    input wire logic [3:0] slot_num,
    input wire logic ignore_io_enable,
    input wire logic [9:0] mem_base,
    input wire logic io_mode,
    input wire logic [eab_pkg::DATA_W-1:0] read_value,
    // write data stream to the user
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [eab_pkg::DATA_W-1:0] wr_data,
    // backplane
    eab_if.slave bus
);
    import eab_pkg::*;
    logic [1:0] st_s1_reg, st_s2_reg;
    logic sel, sel_reg, rd_reg, wr_seen_reg, push, fifo_ready;
    logic en_ok;
    // start strobe is from the link, four flops before push uses it
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_s1_reg <= 2'b11;
            st_s2_reg <= 2'b11;
        end else begin
            st_s1_reg <= {st_s1_reg[0], bus.start_n};
            st_s2_reg <= {st_s2_reg[0], st_s1_reg[1]};
        end
    end
    // io decode may ignore the enable for simple masters
    assign en_ok = ignore_io_enable
        || !bus.slot_io_addr_enable_n[slot_num]; // R12
    always_comb begin
        sel = 1'b0;
        if (!bus.start_n) begin
            if (bus.mem_io == QUAL_MEM) begin
                sel = !io_mode && {bus.mid_addr_byte,
                    bus.low_addr[15:MEM_DEC_LSB]} == mem_base; // R13
            end else begin
                sel = io_mode && en_ok;
            end
        end
    end
    // selection and one push per write transfer
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
        end else begin
            sel_reg <= sel;
            rd_reg <= sel && bus.wr_rd == QUAL_RD;
            if (push) wr_seen_reg <= 1'b1;
            else if (!sel) wr_seen_reg <= 1'b0;
        end
    end
    assign push = sel_reg && bus.wr_rd == QUAL_WR && !wr_seen_reg
                  && st_s2_reg[1] == 1'b0 && fifo_ready;
    // size answers, open collector low when selected; half in io mode only, word and memory half in memory mode only
    assign bus.slave_byte_xfer_n = !sel; // R17 R23
    assign bus.slave_half_xfer_n = !(sel && io_mode); // R18
    assign bus.slave_word_xfer_n = !(sel && !io_mode); // R19
    assign bus.memory_half_word_cap_n = !(sel && !io_mode); // R13
    assign bus.slave_burst_cap_n = !sel; // R20
    assign bus.s_data_o = read_value;
    assign bus.s_data_oe_n = !rd_reg; // R1
    eab_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(bus.data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_data)
    );
endmodule : eab_slave
`default_nettype wire

/* File: tb/eab_chk.sv */
// checker watching the backplane between master and slave ends
`timescale 1ns/1ps
`default_nettype none
module eab_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // backplane signals
    input wire logic link_clk,
    input wire logic m_data_oe_n,
    input wire logic s_data_oe_n,
    input wire logic [15:0] low_addr,
    input wire logic mem_io,
    input wire logic wr_rd,
    input wire logic start_n,
    input wire logic [eab_pkg::NUM_SLOTS:1] slot_io_addr_enable_n
);
    import eab_pkg::*;
    logic [NUM_SLOTS:1] slot_exp;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // only the slot named by the top nibble may see a slot-range enable
    always_comb begin
        slot_exp = '1;
        if (low_addr[15:12] >= 4'h1 && low_addr[15:12] <= 4'he) begin
            slot_exp[low_addr[15:12]] = 1'b0;
        end
    end
    a_no_data_clash: assert property (m_data_oe_n || s_data_oe_n)
        else $error("both ends drive data");
    a_master_data_dir: assert property (!m_data_oe_n |-> wr_rd == QUAL_WR)
        else $error("master drives data outside a write");
    a_slave_data_dir: assert property (!s_data_oe_n |-> wr_rd == QUAL_RD)
        else $error("slave drives data outside a read");
    a_link_half_period: assert property ($rose(link_clk) |=>
        $stable(link_clk)[*3] ##1 $fell(link_clk))
        else $error("link clock high phase not four cycles");
    a_io_shared_all: assert property (!start_n && mem_io == QUAL_IO
        && low_addr[9:8] != 2'h0 |-> slot_io_addr_enable_n == '0)
        else $error("shared io range not enabled to all slots");
    a_io_slot_only: assert property (!start_n && mem_io == QUAL_IO
        && low_addr[9:8] == 2'h0 |-> slot_io_addr_enable_n == slot_exp)
        else $error("slot io range enable pattern wrong");
    a_mem_no_enable: assert property (!start_n && mem_io == QUAL_MEM
        |-> slot_io_addr_enable_n == '1)
        else $error("slot io enable during memory cycle");
    a_qual_held: assert property (!start_n && $past(!start_n)
        |-> $stable(mem_io) && $stable(wr_rd) && $stable(low_addr))
        else $error("qualifiers moved during a cycle");
    a_start_bounded: assert property ($fell(start_n) |-> ##[1:16] start_n)
        else $error("start strobe held too long");
endmodule : eab_chk
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench joining master and slave across the backplane
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eab_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [NUM_SLOTS:1] slot_master_req_n = '1;
    logic [NUM_SLOTS:1] slot_master_grant_n;
    logic legacy_bus_req_n = 1'b1;
    logic cmd_valid = 1'b0, cmd_ready, cmd_mem = 1'b0, cmd_write = 1'b0;
    logic [31:0] cmd_addr = '0, cmd_wdata = '0, rsp_rdata, wr_data;
    logic [31:0] read_value = '0;
    logic [3:0] cmd_lanes = 4'hf;
    logic burst_capable = 1'b1, rsp_valid, wr_valid, wr_ready = 1'b0;
    logic ignore_io_enable = 1'b0, io_mode = 1'b0;
    eab_width_t rsp_width;
    logic half_n_seen, slv_burst_n_seen;
    int bad_count = 0;
    int checks = 0;
    eab_if bus ();
    eab_master i_eab_master (.mclk(mclk), .rst(rst),
        .slot_master_req_n(slot_master_req_n),
        .legacy_bus_req_n(legacy_bus_req_n), .slot_dma_req_n(14'h3fff),
        .slot_master_grant_n(slot_master_grant_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_lanes(cmd_lanes), .cmd_mem(cmd_mem), .cmd_write(cmd_write),
        .burst_capable(burst_capable), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_width(rsp_width), .bus(bus));
    eab_slave i_eab_slave (.mclk(mclk), .rst(rst), .slot_num(4'h3),
        .ignore_io_enable(ignore_io_enable), .mem_base(10'h001),
        .io_mode(io_mode), .read_value(read_value), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .bus(bus));
    eab_chk i_eab_chk (.mclk(mclk), .rst(rst), .link_clk(bus.link_clk),
        .m_data_oe_n(bus.m_data_oe_n), .s_data_oe_n(bus.s_data_oe_n),
        .low_addr(bus.low_addr), .mem_io(bus.mem_io), .wr_rd(bus.wr_rd),
        .start_n(bus.start_n),
        .slot_io_addr_enable_n(bus.slot_io_addr_enable_n));
    // 40 MHz system clock
    always #12.5 mclk = ~mclk;
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // one transfer; wire fields captured on the last start cycle
    task automatic xfer(input logic [31:0] a, input logic [31:0] d,
                        input logic mem, input logic wr);
        int n;
        logic [7:0] up, mid;
        logic [3:0] be;
        logic mi, wd, bn;
        @(negedge mclk);
        half_n_seen = 1'bx;
        slv_burst_n_seen = 1'bx;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_mem = mem;
        cmd_write = wr;
        cmd_valid = 1'b1;
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (n = 0; n < 60 && rsp_valid !== 1'b1; n++) begin
            if (bus.start_n === 1'b0) begin
                up = bus.upper_addr_byte_n;
                mid = bus.mid_addr_byte;
                be = bus.byte_lane_enable_n;
                mi = bus.mem_io;
                wd = bus.wr_rd;
                bn = bus.master_burst_cap_n;
                half_n_seen = bus.master_half_word_n;
                slv_burst_n_seen = bus.slave_burst_cap_n;
            end
            @(negedge mclk);
        end
        if (rsp_valid !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        chk("upper", 32'(up), 32'(8'(~a[31:24])));
        chk("mid", 32'(mid), 32'(a[23:16]));
        chk("lanes", 32'(be), 32'(4'(~cmd_lanes)));
        chk("mem_io", 32'(mi), 32'(mem));
        chk("wr_rd", 32'(wd), 32'(wr));
        chk("burst", 32'(bn), 32'(!burst_capable));
    endtask : xfer
    // arbitration: lowest requester wins, legacy request never hands over
    task automatic t_grant();
        logic [NUM_SLOTS:1] exp;
        int n;
        exp = '1;
        exp[2] = 1'b0;
        chk("grant_idle", 32'(slot_master_grant_n), 32'h3fff);
        slot_master_req_n[5] = 1'b0;
        slot_master_req_n[2] = 1'b0;
        for (n = 0; n < 16 && slot_master_grant_n === '1; n++) @(negedge mclk);
        chk("grant", 32'(slot_master_grant_n), 32'(exp));
        chk("ready_granted", 32'(cmd_ready), 32'h0);
        slot_master_req_n = '1;
        for (n = 0; n < 16 && slot_master_grant_n !== '1; n++) @(negedge mclk);
        chk("grant_off", 32'(slot_master_grant_n), 32'h3fff);
        legacy_bus_req_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk("legacy_grant", 32'(slot_master_grant_n), 32'h3fff);
        chk("legacy_ready", 32'(cmd_ready), 32'h1);
        legacy_bus_req_n = 1'b1;
    endtask : t_grant
    // memory writes buffered while the user stalls, then drained; one read hit and one miss
    task automatic t_mem();
        int n, k;
        for (k = 0; k < 3; k++) begin
            xfer(32'hc300_4000 + 32'(k * 4), 32'h1234_5600 + 32'(k),
                 QUAL_MEM, QUAL_WR);
            chk("wr_width", 32'(rsp_width), 32'(EAB_W32));
            chk("wr_half", 32'(half_n_seen), 32'h1);
            chk("wr_slv_burst", 32'(slv_burst_n_seen), 32'h0);
        end
        chk("wr_valid", 32'(wr_valid), 32'h1);
        wr_ready = 1'b1;
        k = 0;
        for (n = 0; n < 20 && k < 3; n++) begin
            if (wr_valid === 1'b1) begin
                chk("wr_data", wr_data, 32'h1234_5600 + 32'(k));
                k++;
            end
            @(negedge mclk);
        end
        chk("drained", 32'(k), 32'h3);
        read_value = 32'h5a5a_a5a5;
        xfer(32'h0000_4010, 32'h0, QUAL_MEM, QUAL_RD);
        chk("rd_data", rsp_rdata, 32'h5a5a_a5a5);
        chk("rd_width", 32'(rsp_width), 32'(EAB_W32));
        xfer(32'h0000_8000, 32'h0, QUAL_MEM, QUAL_RD);
        chk("miss_data", rsp_rdata, 32'hffff_ffff);
        chk("miss_width", 32'(rsp_width), 32'(EAB_W8));
    endtask : t_mem
    // io reads across shared, own-slot, foreign-slot and ignore cases
    task automatic t_io();
        logic [15:0] ia [4] = '{16'h3000, 16'h5000, 16'h0100, 16'h5000};
        logic hit [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        int i;
        io_mode = 1'b1;
        cmd_lanes = 4'h1;
        burst_capable = 1'b0;
        read_value = 32'h0000_0077;
        for (i = 0; i < 4; i++) begin
            ignore_io_enable = (i == 3);
            xfer({16'h0, ia[i]}, 32'h0, QUAL_IO, QUAL_RD);
            chk("io_data", 32'(rsp_rdata[7:0]), hit[i] ? 32'h77 : 32'hff);
            chk("io_width", 32'(rsp_width),
                32'(hit[i] ? EAB_W16 : EAB_W8));
            chk("io_half", 32'(half_n_seen), hit[i] ? 32'h0 : 32'h1);
            chk("io_slv_burst", 32'(slv_burst_n_seen),
                hit[i] ? 32'h0 : 32'h1);
        end
    endtask : t_io
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        t_grant();
        t_mem();
        t_io();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
